// ==== shared/avm_pkg.sv ====
// Constants shared by the auxiliary voltage monitor register bank.
package avm_pkg;

    // ========================================================================
    // Widths
    localparam int ADC_W  = 12;
    localparam int WORD_W = 16;
    localparam int CMD_W  = 8;
    localparam int STAT_W = 8;

    // ========================================================================
    // Command codes
    localparam logic [7:0] CMD_AUX_VOLTAGE_READING   = 8'hdd;
    localparam logic [7:0] CMD_AUX_OV_WARN_THRESHOLD = 8'hde;
    localparam logic [7:0] CMD_AUX_UV_WARN_THRESHOLD = 8'hdf;
    localparam logic [7:0] CMD_AUX_WARNING_STATUS    = 8'hf6;
    // Standard management-bus fault clearing command, a send byte with no data.
    localparam logic [7:0] CMD_CLEAR_FAULTS          = 8'h03;

    // ========================================================================
    // Reset values
    localparam logic [11:0] RST_AUX_READING = 12'h000;
    localparam logic [11:0] RST_OV_THRESH   = 12'hfff;
    localparam logic [11:0] RST_UV_THRESH   = 12'h000;
    localparam logic [15:0] RST_WORD        = 16'h0000;

    // ========================================================================
    // Status field positions
    localparam int STAT_OV_BIT = 7;
    localparam int STAT_UV_BIT = 6;

    // ========================================================================
    // Pad for the reserved upper bits of 12-bit registers
    localparam logic [3:0] RSVD_HI = 4'h0;

endpackage

// ==== shared/avm_flag_if.sv ====
// Carrier between the compare logic and one sticky warning latch.
`timescale 1ns/1ps
interface avm_flag_if;
    logic set;
    logic clr;
    logic flag;

    modport core
    (
        output set,
        output clr,
        input  flag
    );

    modport latch
    (
        input  set,
        input  clr,
        output flag
    );
endinterface

// ==== hdl/avm_flag.sv ====
// One sticky warning flag with set priority over clear.
`timescale 1ns/1ps
module avm_flag
    import avm_pkg::*;
(
    input  wire logic mclk,
    input  wire logic reset,
    avm_flag_if.latch fl
);

    logic flag_q;

    // ========================================================================
    // Sticky latch
    // A new violation seen in the clearing cycle is kept, so no event is lost.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            flag_q <= 1'b0;
        end
        else if (fl.set)
        begin
            flag_q <= 1'b1;
        end
        else if (fl.clr)
        begin
            flag_q <= 1'b0;
        end
    end

    assign fl.flag = flag_q;

endmodule

// ==== hdl/avm_regs.sv ====
// Auxiliary voltage monitor registers: reading, warning thresholds and status.
//
// Summary of operation
// - Reading holds 12-bit code, upper four zero.
// - Overvoltage threshold read-write, resets to all ones.
// - Undervoltage threshold read-write, resets to zero.
// - Bit 7 latches on overvoltage warning.
// - Bit 6 latches on undervoltage warning.
// - Status bits 5..0 zero, status resets zero.
`timescale 1ns/1ps
module avm_regs
    import avm_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic              conv_valid,
    input  wire logic [ADC_W-1:0]  conv_code,
    input  wire logic              cmd_valid,
    input  wire logic              cmd_write,
    input  wire logic [CMD_W-1:0]  cmd_code,
    input  wire logic [WORD_W-1:0] cmd_wdata,
    output logic                   cmd_done,
    output logic                   cmd_nack,
    output logic [WORD_W-1:0]      rd_data,
    output logic                   ov_warn,
    output logic                   uv_warn
);

    // ========================================================================
    // Storage
    logic [ADC_W-1:0]  reading_q;
    logic [ADC_W-1:0]  ov_thresh_q;
    logic [ADC_W-1:0]  uv_thresh_q;
    logic              cmd_done_q;
    logic              cmd_nack_q;
    logic [WORD_W-1:0] rd_data_q;
    logic              ov_warn_q;
    logic              uv_warn_q;

    // ========================================================================
    // Decode
    logic              hit_reading;
    logic              hit_ov;
    logic              hit_uv;
    logic              hit_status;
    logic              hit_clear;
    logic              wr_ov;
    logic              wr_uv;
    logic              do_clear;
    logic              bad_cmd;
    logic [STAT_W-1:0] status_word;
    logic [WORD_W-1:0] rd_data_d;

    assign hit_reading = (cmd_code == CMD_AUX_VOLTAGE_READING);
    assign hit_ov      = (cmd_code == CMD_AUX_OV_WARN_THRESHOLD);
    assign hit_uv      = (cmd_code == CMD_AUX_UV_WARN_THRESHOLD);
    assign hit_status  = (cmd_code == CMD_AUX_WARNING_STATUS);
    assign hit_clear   = (cmd_code == CMD_CLEAR_FAULTS);

    assign wr_ov    = cmd_valid && cmd_write && hit_ov;
    assign wr_uv    = cmd_valid && cmd_write && hit_uv;
    assign do_clear = cmd_valid && cmd_write && hit_clear;

    // Writes to read-only registers, reads of the clear command and any
    // command this bank does not own are refused with a not-acknowledge.
    always_comb
    begin
        if (cmd_write)
        begin
            bad_cmd = !(hit_ov || hit_uv || hit_clear);
        end
        else
        begin
            bad_cmd = !(hit_reading || hit_ov || hit_uv || hit_status);
        end
    end

    // ========================================================================
    // Conversion capture
    // Latch new code.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            reading_q <= RST_AUX_READING;
        end
        else if (conv_valid)
        begin
            reading_q <= conv_code;
        end
    end

    // ========================================================================
    // Thresholds
    // Overvoltage threshold write.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ov_thresh_q <= RST_OV_THRESH;
        end
        else if (wr_ov)
        begin
            ov_thresh_q <= cmd_wdata[ADC_W-1:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            uv_thresh_q <= RST_UV_THRESH;
        end
        else if (wr_uv)
        begin
            uv_thresh_q <= cmd_wdata[ADC_W-1:0];
        end
    end

    // ========================================================================
    // Warning latches
    // The compare uses the incoming code so a violation is flagged in the
    // same edge that stores the conversion; a threshold written in that same
    // edge takes effect only from the next conversion.
    avm_flag_if ov_if ();
    avm_flag_if uv_if ();

    assign ov_if.set = conv_valid && (conv_code > ov_thresh_q);
    assign uv_if.set = conv_valid && (conv_code < uv_thresh_q);
    assign ov_if.clr = do_clear;
    assign uv_if.clr = do_clear;

    avm_flag u_ov_flag
    (
        .mclk  (mclk),
        .reset (reset),
        .fl    (ov_if.latch)
    );

    avm_flag u_uv_flag
    (
        .mclk  (mclk),
        .reset (reset),
        .fl    (uv_if.latch)
    );

    // ========================================================================
    // Status word
    // Reserved bits zero.
    always_comb
    begin
        status_word              = '0;
        status_word[STAT_OV_BIT] = ov_if.flag;
        status_word[STAT_UV_BIT] = uv_if.flag;
    end

    // ========================================================================
    // Read mux
    // Upper bits zero.
    always_comb
    begin
        rd_data_d = RST_WORD;
        if (cmd_valid && !cmd_write)
        begin
            case (cmd_code)
                CMD_AUX_VOLTAGE_READING:   rd_data_d = {RSVD_HI, reading_q};
                CMD_AUX_OV_WARN_THRESHOLD: rd_data_d = {RSVD_HI, ov_thresh_q};
                CMD_AUX_UV_WARN_THRESHOLD: rd_data_d = {RSVD_HI, uv_thresh_q};
                CMD_AUX_WARNING_STATUS:    rd_data_d = {8'h00, status_word};
                default:                   rd_data_d = RST_WORD;
            endcase
        end
    end

    // ========================================================================
    // Answer to the command engine
    // Read data is held until the next read command so the serial engine can
    // shift it out at its own pace without a further handshake.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rd_data_q <= RST_WORD;
        end
        else if (cmd_valid && !cmd_write)
        begin
            rd_data_q <= rd_data_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            cmd_done_q <= 1'b0;
            cmd_nack_q <= 1'b0;
        end
        else
        begin
            cmd_done_q <= cmd_valid;
            cmd_nack_q <= cmd_valid && bad_cmd;
        end
    end

    // ========================================================================
    // Flag mirrors for the alert logic
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ov_warn_q <= 1'b0;
            uv_warn_q <= 1'b0;
        end
        else
        begin
            ov_warn_q <= ov_if.flag;
            uv_warn_q <= uv_if.flag;
        end
    end

    assign cmd_done = cmd_done_q;
    assign cmd_nack = cmd_nack_q;
    assign rd_data  = rd_data_q;
    assign ov_warn  = ov_warn_q;
    assign uv_warn  = uv_warn_q;

endmodule

// ==== sim/avm_regs_chk.sv ====
// Port checker for the aux monitor register bank.
`timescale 1ns/1ps
module avm_regs_chk
    import avm_pkg::*;
(
    input wire logic              mclk,
    input wire logic              reset,
    input wire logic              conv_valid,
    input wire logic [ADC_W-1:0]  conv_code,
    input wire logic              cmd_valid,
    input wire logic              cmd_write,
    input wire logic [CMD_W-1:0]  cmd_code,
    input wire logic [WORD_W-1:0] cmd_wdata,
    input wire logic              cmd_done,
    input wire logic              cmd_nack,
    input wire logic [WORD_W-1:0] rd_data,
    input wire logic              ov_warn,
    input wire logic              uv_warn
);
    // ========================================================================
    // Assertions
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire rd = cmd_valid && !cmd_write;
    wire wr = cmd_valid && cmd_write;
    wire clr = wr && cmd_code == CMD_CLEAR_FAULTS && !conv_valid;
    a_done_follows: assert property (cmd_valid |=> cmd_done)
        else $error("no done after command");
    a_done_caused: assert property (cmd_done |-> $past(cmd_valid))
        else $error("done without command");
    a_ro_refused: assert property (wr && cmd_code inside {8'hdd, 8'hf6} |=> cmd_nack)
        else $error("write to read-only accepted");
    a_word_hi_zero: assert property (rd && cmd_code inside {8'hdd, 8'hde, 8'hdf}
        |=> rd_data[15:12] == 4'h0)
        else $error("upper bits not zero");
    a_stat_low_zero: assert property (rd && cmd_code == 8'hf6 |=> rd_data[5:0] == 6'h00)
        else $error("status low bits not zero");
    a_ov_cause: assert property ($rose(ov_warn) |-> $past(conv_valid, 2))
        else $error("ov flag without conversion");
    a_uv_cause: assert property ($rose(uv_warn) |-> $past(conv_valid, 2))
        else $error("uv flag without conversion");
    a_clear_flags: assert property (clr |=> ##1 !ov_warn && !uv_warn)
        else $error("flags not cleared");
    a_reset_quiet: assert property (disable iff (1'b0) reset |=> !cmd_done && !cmd_nack
        && !ov_warn && !uv_warn && rd_data == 16'h0000)
        else $error("outputs not cleared by reset");
    c_nack: cover property (cmd_nack);
    c_ov: cover property ($rose(ov_warn));
    c_uv: cover property ($rose(uv_warn));
    c_clr: cover property (clr);
endmodule

bind avm_regs avm_regs_chk chk (.mclk(mclk), .reset(reset), .conv_valid(conv_valid),
    .conv_code(conv_code), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .cmd_nack(cmd_nack), .rd_data(rd_data),
    .ov_warn(ov_warn), .uv_warn(uv_warn));

// ==== sim/avm_host.sv ====
// Host command engine model that drives the command port.
`timescale 1ns/1ps
module avm_host
    import avm_pkg::*;
(
    input  wire logic              mclk,
    output logic                   cmd_valid,
    output logic                   cmd_write,
    output logic [CMD_W-1:0]       cmd_code,
    output logic [WORD_W-1:0]      cmd_wdata,
    input  wire logic              cmd_done,
    input  wire logic              cmd_nack,
    input  wire logic [WORD_W-1:0] rd_data
);
    // ========================================================================
    // Transfers
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] r, output logic nk, output logic to);
        int i;
        to = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code = c;
        cmd_wdata = d;
        @(negedge mclk);
        cmd_valid = 1'b0;
        // Released word is inverted so a late sample cannot pass by luck.
        cmd_wdata = ~d;
        for (i = 0; i < 3 && to; i++)
        begin
            if (cmd_done === 1'b1)
                to = 1'b0;
            r = rd_data;
            nk = cmd_nack;
            if (to)
                @(negedge mclk);
        end
    endtask
endmodule

// ==== sim/aux_voltage_monitor_regs_test.sv ====
// Testbench of the aux monitor register bank.
`timescale 1ns/1ps
module aux_voltage_monitor_regs_test
    import avm_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic conv_valid = 1'b0;
    logic [11:0] conv_code = 12'h000;
    logic cmd_valid, cmd_write, cmd_done, cmd_nack, ov_warn, uv_warn;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rd_data;
    int fail_count = 0;
    int n_checks = 0;
    always #25 mclk = ~mclk;
    avm_regs uut (.mclk(mclk), .reset(reset), .conv_valid(conv_valid), .conv_code(conv_code),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .cmd_nack(cmd_nack),
        .rd_data(rd_data), .ov_warn(ov_warn), .uv_warn(uv_warn));
    avm_host host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_done(cmd_done),
        .cmd_nack(cmd_nack), .rd_data(rd_data));
    // ========================================================================
    // Helpers
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
                       input logic [15:0] er, input logic en);
        logic [15:0] r;
        logic nk, to;
        host.xfer(w, c, d, r, nk, to);
        if (to)
        begin
            fail_count++;
            tally_and_finish();
        end
        else
        begin
            chk("nack", {15'h0, en}, {15'h0, nk});
            if (!w)
                chk("read word", er, r);
        end
    endtask
    task automatic conv(input logic [11:0] c);
        @(negedge mclk);
        conv_valid = 1'b1;
        conv_code = c;
        @(negedge mclk);
        conv_valid = 1'b0;
        conv_code = ~c;
    endtask
    // ========================================================================
    // Scenarios
    task automatic t_reset();
        cmd(1'b0, 8'hdd, 16'h0000, 16'h0000, 1'b0);
        cmd(1'b0, 8'hde, 16'h0000, 16'h0fff, 1'b0);
        cmd(1'b0, 8'hdf, 16'h0000, 16'h0000, 1'b0);
        cmd(1'b0, 8'hf6, 16'h0000, 16'h0000, 1'b0);
        chk("warn pins", 16'h0, {14'h0, ov_warn, uv_warn});
    endtask
    task automatic t_limits();
        cmd(1'b1, 8'hde, 16'hf800, 16'h0000, 1'b0);
        cmd(1'b0, 8'hde, 16'h0000, 16'h0800, 1'b0);
        cmd(1'b1, 8'hdf, 16'hf100, 16'h0000, 1'b0);
        cmd(1'b0, 8'hdf, 16'h0000, 16'h0100, 1'b0);
        cmd(1'b1, 8'hdd, 16'h0123, 16'h0000, 1'b1);
        cmd(1'b1, 8'hf6, 16'h00ff, 16'h0000, 1'b1);
        // A refused read must reload zero, not leave the last word standing.
        cmd(1'b0, CMD_CLEAR_FAULTS, 16'h0000, 16'h0000, 1'b1);
        cmd(1'b1, 8'h55, 16'h0abc, 16'h0000, 1'b1);
        cmd(1'b0, 8'hdd, 16'h0000, 16'h0000, 1'b0);
        cmd(1'b0, 8'hde, 16'h0000, 16'h0800, 1'b0);
    endtask
    task automatic t_warn();
        conv(12'h800);
        cmd(1'b0, 8'hf6, 16'h0000, 16'h0000, 1'b0);
        conv(12'h801);
        cmd(1'b0, 8'hdd, 16'h0000, 16'h0801, 1'b0);
        conv(12'h400);
        cmd(1'b0, 8'hf6, 16'h0000, 16'h0080, 1'b0);
        chk("ov_warn", 16'h1, {15'h0, ov_warn});
        conv(12'h100);
        cmd(1'b0, 8'hf6, 16'h0000, 16'h0080, 1'b0);
        conv(12'h0ff);
        cmd(1'b0, 8'hf6, 16'h0000, 16'h00c0, 1'b0);
        chk("uv_warn", 16'h1, {15'h0, uv_warn});
        cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000, 16'h0000, 1'b0);
        cmd(1'b0, 8'hf6, 16'h0000, 16'h0000, 1'b0);
        chk("warn pins", 16'h0, {14'h0, ov_warn, uv_warn});
    endtask
    task automatic t_set_wins();
        // Violation and clear land on one edge; the new violation must survive.
        fork
            conv(12'hfff);
            cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000, 16'h0000, 1'b0);
        join
        cmd(1'b0, 8'hf6, 16'h0000, 16'h0080, 1'b0);
        chk("ov_warn", 16'h1, {15'h0, ov_warn});
    endtask
    task automatic t_mid_reset();
        @(negedge mclk);
        reset = 1'b1;
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        t_reset();
    endtask
    initial
    begin
        repeat (5) @(negedge mclk);
        reset = 1'b0;
        t_reset();
        t_limits();
        t_warn();
        t_set_wins();
        t_mid_reset();
        tally_and_finish();
    end
endmodule
